// File: pkg/pwm_timer_pkg.sv
package pwm_timer_pkg;

	// Register offsets on the plain register port
	localparam logic [7:0] ADDR_MODE   = 8'h00;
	localparam logic [7:0] ADDR_COUNT  = 8'h01;
	localparam logic [7:0] ADDR_RELOAD = 8'h02;
	localparam logic [7:0] ADDR_DUTY   = 8'h03;
	localparam logic [7:0] ADDR_CTRL   = 8'h04;

	// Reset values
	localparam logic [7:0] MODE_RST  = 8'h00;
	localparam logic [7:0] COUNT_RST = 8'h00;
	localparam logic [7:0] RLD_RST   = 8'h00;
	localparam logic [7:0] DUTY_RST  = 8'h00;
	localparam logic [7:0] CTRL_RST  = 8'h00;

	// Counter limits and prescaler mask base
	localparam logic [7:0] CNT_FULL = 8'hff;
	localparam logic [7:0] CNT_ONE  = 8'h01;
	localparam logic [7:0] PRE_FULL = 8'hff;
	localparam logic [7:0] PRE_ZERO = 8'h00;

	// Program vector taken on the overflow interrupt
	localparam logic [15:0] IRQ_VECTOR = 16'h000c;

	// Field positions in the control register
	localparam int CTRL_FLAG_BIT = 0;
	localparam int CTRL_BUSY_BIT = 4;

	// Mode register layout, bit 7 down to bit 0
	typedef struct packed {
		logic       run;
		logic [2:0] rate;
		logic       cks;
		logic       phase;
		logic       pulse;
		logic       pwm;
	} mode_t;

	// Control register layout, bit 7 down to bit 0
	typedef struct packed {
		logic [3:0] rsvd;
		logic       edge_sel;
		logic       trig_src;
		logic       ien;
		logic       flag;
	} ctrl_t;

	// Shared pin drive pair
	typedef struct packed {
		logic out;
		logic oe;
	} pin_t;

endpackage : pwm_timer_pkg

// File: core/pwm_timer.sv
`timescale 1ns/1ps
module pwm_timer
	import pwm_timer_pkg::*;
(
	input  wire logic       clk_sys,     // System clock, 100 MHz
	input  wire logic       resetn,      // Synchronous reset, active low
	input  wire logic [7:0] reg_addr,    // Register address
	input  wire logic [7:0] reg_wdata,   // Register write data
	input  wire logic       reg_wr,      // Write strobe
	input  wire logic       reg_rd,      // Read strobe
	output logic      [7:0] reg_rdata,   // Read data, cycle after strobe
	input  wire logic       fcpu_en,     // Instruction clock enable pulse
	input  wire logic       fhosc_en,    // Fast oscillator enable pulse
	input  wire logic       cmp0_out,    // Comparator 0 output level
	input  wire logic       comp_tmo,    // Companion timer timeout pulse
	input  wire logic       gpio_out,    // GPIO output value for the pin
	input  wire logic       gpio_oe,     // GPIO output enable for the pin
	output logic            pin_out,     // Shared pin output value
	output logic            pin_oe,      // Shared pin output enable
	output logic            timer_irq,   // Overflow interrupt request
	output logic            wake_req     // System wake request, never raised
);

	// State registers
	mode_t      mode_r;
	mode_t      mode_nxt;
	ctrl_t      ctrl_r;
	ctrl_t      ctrl_nxt;
	logic [7:0] count_r;
	logic [7:0] count_nxt;
	logic [7:0] rld_buf_r;
	logic [7:0] rld_act_r;
	logic [7:0] rld_act_nxt;
	logic [7:0] duty_r;
	logic [7:0] pre_r;
	logic [7:0] pre_nxt;
	logic       busy_r;
	logic       busy_nxt;
	logic       cmp_s1_r;
	logic       cmp_s2_r;
	logic       cmp_s3_r;
	pin_t       pin_r;
	pin_t       pin_nxt;
	logic [7:0] rdata_r;
	logic [7:0] rdata_nxt;
	logic       irq_r;
	logic       wake_r;

	// Register decode
	wire wr_mode  = reg_wr && (reg_addr == ADDR_MODE);
	wire wr_count = reg_wr && (reg_addr == ADDR_COUNT);
	wire wr_rld   = reg_wr && (reg_addr == ADDR_RELOAD);
	wire wr_duty  = reg_wr && (reg_addr == ADDR_DUTY);
	wire wr_ctrl  = reg_wr && (reg_addr == ADDR_CTRL);

	// Prescaler source and divide mask
	wire       src_en   = mode_r.cks ? fhosc_en : fcpu_en;
	wire [7:0] pre_mask = PRE_FULL >> mode_r.rate;
	wire       tick     = src_en && ((pre_r & pre_mask) == pre_mask);

	// Comparator edge from the synchronised level
	wire rise_edge = cmp_s2_r && !cmp_s3_r;
	wire fall_edge = !cmp_s2_r && cmp_s3_r;
	wire cmp_edge  = ctrl_r.edge_sel ? fall_edge : rise_edge;

	// One-shot trigger selection
	wire trig_sel = ctrl_r.trig_src ? cmp_edge : mode_r.pwm;
	wire trig_req = mode_r.run && mode_r.pulse && !busy_r && trig_sel;
	wire kill     = comp_tmo && busy_r;

	// Counting enable and overflow
	wire cnt_go = tick && mode_r.run && (!mode_r.pulse || busy_r);
	wire ovf    = cnt_go && (count_r == CNT_FULL);
	wire sw_end = ovf && mode_r.pulse && !ctrl_r.trig_src;

	// Reload buffer moves to the active copy at overflow or while idle
	wire rld_move = ovf || !mode_r.run || (mode_r.pulse && !busy_r);

	// Output levels before phase selection
	wire pwm_hi   = (count_r < duty_r);
	wire pulse_hi = (count_nxt != CNT_FULL);  // Aligned with the counter, not one cycle behind

	// Prescaler restarts on a trigger so the first tick is a full period
	always_comb
	begin
		pre_nxt = pre_r;
		if (!mode_r.run || trig_req)
			pre_nxt = PRE_ZERO;
		else if (src_en)
			pre_nxt = pre_r + CNT_ONE;
	end

	// Counter: software write, then reload, then increment
	always_comb
	begin
		count_nxt = count_r;
		if (wr_count)
			count_nxt = reg_wdata;
		else if (ovf)
			count_nxt = rld_act_nxt;                // New reload lands at this overflow
		else if (cnt_go)
			count_nxt = count_r + CNT_ONE;
	end

	// Active reload copy
	assign rld_act_nxt = rld_move ? rld_buf_r : rld_act_r;

	// Mode register; timeout clears run and pulse, overflow ends a software shot
	always_comb
	begin
		mode_nxt = wr_mode ? mode_t'(reg_wdata) : mode_r;
		if (sw_end && !wr_mode)
			mode_nxt.pwm = 1'b0;
		if (kill)
		begin
			mode_nxt.run   = 1'b0;
			mode_nxt.pulse = 1'b0;
		end
	end

	// Control register; overflow sets the flag and wins over a clear
	always_comb
	begin
		ctrl_nxt = wr_ctrl ? ctrl_t'(reg_wdata) : ctrl_r;
		ctrl_nxt.rsvd = 4'h0;
		ctrl_nxt.flag = ovf || (ctrl_r.flag && !(wr_ctrl && !reg_wdata[CTRL_FLAG_BIT]));
		if (kill)
			ctrl_nxt.trig_src = 1'b0;
	end

	// Pulse in progress
	always_comb
	begin
		busy_nxt = busy_r;
		if (trig_req)
			busy_nxt = 1'b1;
		if (ovf || kill || !mode_r.pulse || !mode_r.run)
			busy_nxt = 1'b0;
	end

	// Pin selection: pulse, PWM, or the GPIO state as it stands
	always_comb
	begin
		pin_nxt.out = gpio_out;
		pin_nxt.oe  = gpio_oe;
		if (mode_r.pulse && busy_nxt)
		begin
			pin_nxt.out = pulse_hi ^ mode_r.phase;
			pin_nxt.oe  = 1'b1;
		end
		else if (!mode_r.pulse && mode_r.pwm)
		begin
			pin_nxt.out = pwm_hi ^ mode_r.phase;
			pin_nxt.oe  = 1'b1;
		end
	end

	// Read data mux; reload is write-only and unmapped reads give zero
	always_comb
	begin
		rdata_nxt = 8'h00;
		if (reg_rd)
		begin
			case (reg_addr)
				ADDR_MODE:  rdata_nxt = mode_r;
				ADDR_COUNT: rdata_nxt = count_r;
				ADDR_DUTY:  rdata_nxt = duty_r;
				ADDR_CTRL:
				begin
					rdata_nxt = ctrl_r;
					rdata_nxt[CTRL_BUSY_BIT] = busy_r;
				end
				default:    rdata_nxt = 8'h00;
			endcase
		end
	end

	// Timer state
	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
		begin
			mode_r    <= mode_t'(MODE_RST);
			ctrl_r    <= ctrl_t'(CTRL_RST);
			count_r   <= COUNT_RST;
			rld_act_r <= RLD_RST;
			pre_r     <= PRE_ZERO;
			busy_r    <= 1'b0;
		end
		else
		begin
			mode_r    <= mode_nxt;
			ctrl_r    <= ctrl_nxt;
			count_r   <= count_nxt;
			rld_act_r <= rld_act_nxt;
			pre_r     <= pre_nxt;
			busy_r    <= busy_nxt;
		end
	end

	// Software-written buffers
	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
		begin
			rld_buf_r <= RLD_RST;
			duty_r    <= DUTY_RST;
		end
		else
		begin
			if (wr_rld)
				rld_buf_r <= reg_wdata;
			if (wr_duty)
				duty_r <= reg_wdata;
		end
	end

	// Comparator synchroniser and edge history
	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
		begin
			cmp_s1_r <= 1'b0;
			cmp_s2_r <= 1'b0;
			cmp_s3_r <= 1'b0;
		end
		else
		begin
			cmp_s1_r <= cmp0_out;
			cmp_s2_r <= cmp_s1_r;
			cmp_s3_r <= cmp_s2_r;
		end
	end

	// Registered outputs
	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
		begin
			pin_r   <= '0;
			rdata_r <= 8'h00;
			irq_r   <= 1'b0;
			wake_r  <= 1'b0;
		end
		else
		begin
			pin_r   <= pin_nxt;
			rdata_r <= rdata_nxt;
			irq_r   <= ctrl_nxt.flag && ctrl_nxt.ien;
			wake_r  <= 1'b0;
		end
	end

	assign pin_out   = pin_r.out;
	assign pin_oe    = pin_r.oe;
	assign reg_rdata = rdata_r;
	assign timer_irq = irq_r;
	assign wake_req  = wake_r;

	// Checks
	sequence sw_shot_end_s;
		sw_end && !wr_mode;
	endsequence

	sequence pin_freed_s;
		!busy_r ##0 (pin_oe == $past(gpio_oe));
	endsequence

	stop_hold_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		(!mode_r.run && !wr_count) |=> $stable(count_r))
		else $error("counter moved while stopped");

	ovf_flag_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		ovf |=> ctrl_r.flag)
		else $error("overflow did not set the flag");

	auto_reload_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		(ovf && !wr_count) |=> (count_r == rld_act_r))
		else $error("counter not reloaded at overflow");

	dbuf_hold_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		!rld_move |=> (rld_act_r == $past(rld_act_r)))
		else $error("reload copy changed mid cycle");

	irq_req_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		(ovf && ctrl_r.ien && !wr_ctrl) |=> timer_irq)
		else $error("interrupt not raised on overflow");

	no_wake_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		!wake_req)
		else $error("timer raised a wake request");

	pwm_pin_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		(mode_r.pwm && !mode_r.pulse) |=> pin_oe && (pin_out == (($past(count_r) < $past(duty_r)) ^ $past(mode_r.phase))))
		else $error("pin not driven with PWM");

	shot_wait_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		(mode_r.pulse && !busy_r && !wr_count) |=> $stable(count_r))
		else $error("one-shot counted before trigger");

	sw_clear_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		sw_shot_end_s |=> !mode_r.pwm ##1 pin_freed_s)
		else $error("software trigger bit not cleared");

	tmo_kill_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		kill |=> (!mode_r.run && !mode_r.pulse && !ctrl_r.trig_src && !busy_r))
		else $error("timeout did not stop the pulse");

	rate_div_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		(tick && !wr_mode) |=> ((pre_r & pre_mask) == PRE_ZERO))
		else $error("prescaler did not wrap after a tick");

endmodule : pwm_timer

// File: testbench/pin_load.sv
`timescale 1ns/1ps
// External load on the shared pin, pulled up when the pin floats
module pin_load
(
	input  wire logic pin_out, // Pin value from the timer
	input  wire logic pin_oe,  // Pin drive enable
	output logic      pad      // Level seen at the pad
);
	// Driven value wins, otherwise the pull-up level
	assign pad = pin_oe ? pin_out : 1'b1;
endmodule : pin_load

// File: testbench/test_timer_pwm_pulse_generator.sv
`timescale 1ns/1ps
module test_timer_pwm_pulse_generator;
	import pwm_timer_pkg::*;
	logic       clk_sys   = 1'b0;
	logic       resetn    = 1'b0;
	logic [7:0] reg_addr  = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic       reg_wr    = 1'b0;
	logic       reg_rd    = 1'b0;
	logic       fcpu_en   = 1'b0;
	logic       fhosc_en  = 1'b0;
	logic       cmp0_out  = 1'b0;
	logic       comp_tmo  = 1'b0;
	logic       gpio_out  = 1'b0;
	logic       gpio_oe   = 1'b0;
	logic [7:0] reg_rdata;
	logic       pin_out;
	logic       pin_oe;
	logic       timer_irq;
	logic       wake_req;
	logic       pad;
	int         n_fail      = 0;
	int         comparisons = 0;

	// 100 MHz system clock
	always #5 clk_sys = ~clk_sys;

	pwm_timer i_dut (.clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fcpu_en(fcpu_en), .fhosc_en(fhosc_en),
		.cmp0_out(cmp0_out), .comp_tmo(comp_tmo), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
		.pin_out(pin_out), .pin_oe(pin_oe), .timer_irq(timer_irq), .wake_req(wake_req));

	pin_load i_load (.pin_out(pin_out), .pin_oe(pin_oe), .pad(pad));

	task automatic final_report;
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : final_report

	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	// Register bus cycles, one idle cycle after each strobe
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		@(posedge clk_sys);
	endtask : wr

	task automatic rc(input logic [7:0] a, input logic [7:0] e, input string nm);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(posedge clk_sys);
		chk(nm, {8'h00, reg_rdata}, {8'h00, e});
	endtask : rc

	// Stop, load count and reload alike, set control
	task automatic setup(input logic [7:0] v, input logic [7:0] c);
		wr(ADDR_MODE, 8'h00);
		wr(ADDR_COUNT, v);
		wr(ADDR_RELOAD, v);
		wr(ADDR_CTRL, c);
	endtask : setup

	// One enable on the chosen source, one on the other source later
	task automatic en(input logic s);
		fcpu_en  <= !s;
		fhosc_en <= s;
		@(posedge clk_sys);
		fcpu_en  <= s;
		fhosc_en <= !s;
		@(posedge clk_sys);
		fcpu_en  <= 1'b0;
		fhosc_en <= 1'b0;
		repeat (2) @(posedge clk_sys);
	endtask : en

	// Enables until the overflow request, then clear the flag
	task automatic per(input logic s, output int n);
		n = 0;
		while (timer_irq !== 1'b1 && n < 1200)
		begin
			en(s);
			n++;
		end
		if (n >= 1200)
		begin
			n_fail++;
			final_report();
		end
		wr(ADDR_CTRL, 8'h02);
		@(posedge clk_sys);
	endtask : per

	task automatic t_reset;
		rc(ADDR_MODE, MODE_RST, "mode");
		rc(ADDR_COUNT, COUNT_RST, "count");
		rc(ADDR_DUTY, DUTY_RST, "duty");
		rc(ADDR_CTRL, CTRL_RST, "ctrl");
		rc(8'h05, 8'h00, "unmapped");
		wr(ADDR_RELOAD, 8'h5a);
		rc(ADDR_RELOAD, 8'h00, "reload write only");
	endtask : t_reset

	task automatic t_rate;
		int n;
		for (int s = 0; s < 2; s++)
			for (int r = 0; r < 8; r++)
			begin
				setup(8'hfe, 8'h02);
				wr(ADDR_MODE, {1'b1, r[2:0], s[0], 3'b000});
				per(s[0], n);
				per(s[0], n);
				chk("period", 16'(n), 16'(2 * (256 >> r)));
			end
	endtask : t_rate

	task automatic t_buf;
		int n;
		setup(8'hfe, 8'h02);
		wr(ADDR_MODE, 8'hf0);
		per(1'b0, n);
		wr(ADDR_RELOAD, 8'hfc);
		per(1'b0, n);
		chk("old reload", 16'(n), 16'd4);
		per(1'b0, n);
		chk("new reload", 16'(n), 16'd8);
		wr(ADDR_MODE, 8'h70);
		en(1'b0);
		repeat (2) en(1'b0);
		rc(ADDR_COUNT, 8'hfc, "held count");
	endtask : t_buf

	task automatic t_pwm;
		int hi;
		int oe;
		setup(8'hfc, 8'h02);
		wr(ADDR_DUTY, 8'hfd);
		gpio_oe <= 1'b1;
		for (int ph = 0; ph < 2; ph++)
		begin
			wr(ADDR_MODE, 8'hf1 | 8'(ph << 2));
			fcpu_en <= 1'b1;
			repeat (20) @(posedge clk_sys);
			hi = 0;
			oe = 0;
			repeat (64)
			begin
				@(posedge clk_sys);
				hi += int'(pad === 1'b1);
				oe += int'(pin_oe === 1'b1);
			end
			chk("pwm high", 16'(hi), ph ? 16'd48 : 16'd16);
			chk("pwm drive", 16'(oe), 16'd64);
			chk("pwm irq", 16'(timer_irq), 16'h0001);
			fcpu_en <= 1'b0;
			wr(ADDR_MODE, 8'h70);
			@(posedge clk_sys);
			chk("gpio back", 16'({pin_oe, pad}), 16'h0002);
		end
	endtask : t_pwm

	task automatic t_pulse;
		int act;
		logic ph;
		logic cs;
		gpio_oe <= 1'b0;
		for (int k = 0; k < 4; k++)
		begin
			ph = k[0];
			cs = k[1];
			cmp0_out <= ph;
			setup(8'hfc, {4'h0, ph, cs, 2'b00});
			wr(ADDR_MODE, {5'b11110, ph, 2'b10});
			fcpu_en <= 1'b1;
			repeat (10) @(posedge clk_sys);
			rc(ADDR_COUNT, 8'hfc, "idle count");
			if (cs)
				cmp0_out <= !ph;
			else
				wr(ADDR_MODE, {5'b11110, ph, 2'b11});
			act = 0;
			repeat (40)
			begin
				@(posedge clk_sys);
				act += int'(pin_oe === 1'b1 && pin_out === !ph);
			end
			chk("pulse width", 16'(act), 16'd6);
			chk("pulse end pin", 16'({pin_oe, pad}), 16'h0001);
			chk("pulse irq", 16'(timer_irq), 16'h0000);
			fcpu_en <= 1'b0;
			rc(ADDR_MODE, {5'b11110, ph, 2'b10}, "trigger bit");
			rc(ADDR_CTRL, {4'h0, ph, cs, 2'b01}, "pulse flag");
			rc(ADDR_COUNT, 8'hfc, "pulse reload");
		end
	endtask : t_pulse

	task automatic t_tmo;
		setup(8'h00, 8'h04);
		wr(ADDR_MODE, 8'hf2);
		fcpu_en  <= 1'b1;
		cmp0_out <= 1'b1;
		repeat (20) @(posedge clk_sys);
		comp_tmo <= 1'b1;
		@(posedge clk_sys);
		comp_tmo <= 1'b0;
		repeat (3) @(posedge clk_sys);
		chk("abort pin", 16'(pin_oe), 16'h0000);
		fcpu_en <= 1'b0;
		rc(ADDR_MODE, 8'h70, "abort mode");
		rc(ADDR_CTRL, 8'h00, "abort ctrl");
	endtask : t_tmo

	// Reset for 12 cycles, then each scenario in turn
	initial
	begin
		repeat (12) @(posedge clk_sys);
		resetn <= 1'b1;
		@(posedge clk_sys);
		t_reset();
		t_rate();
		t_buf();
		t_pwm();
		t_pulse();
		t_tmo();
		chk("wake", 16'(wake_req), 16'h0000);
		final_report();
	end
endmodule : test_timer_pwm_pulse_generator
